// ---- pkg/iatc_regs.svh ----
// iatc_regs.svh: offsets, field positions, reset values and timing counts
// assumes a 32-bit Avalon-MM slave with byte addresses, one word per register
`ifndef IATC_REGS_SVH
`define IATC_REGS_SVH

// ==========================================
// register byte offsets
`define IATC_OFS_CTRL   6'h00
`define IATC_OFS_CMD    6'h04
`define IATC_OFS_MCOUNT 6'h08
`define IATC_OFS_BCOUNT 6'h0c
`define IATC_OFS_EXPDUR 6'h10
`define IATC_OFS_RATE   6'h14
`define IATC_OFS_LAG    6'h18
`define IATC_OFS_STAT   6'h1c
`define IATC_OFS_ACHV   6'h20
`define IATC_OFS_LEFT   6'h24

// ==========================================
// command bits and control width
`define IATC_CMD_BEGIN 0
`define IATC_CMD_END   1
`define IATC_CMD_SOFT  2
`define IATC_CTRL_W    16

// ==========================================
// reset values
`define IATC_CTRL_RST   16'h0020
`define IATC_COUNT_RST  16'h0001
`define IATC_EXPDUR_RST 20'h003e8
`define IATC_RATE_RST   20'h0000a
`define IATC_LAG_RST    20'h00000

// ==========================================
// timing
`define IATC_CLK_HZ   200000000
`define IATC_US_PER_S 1000000
`define IATC_RO_US    10
`define IATC_WIN_S    1

`endif

// ---- pkg/iatc_pkg.sv ----
// iatc_pkg: mode, control and state types of the acquisition sequencer
// assumes iatc_regs.svh holds all numeric constants
`default_nettype none
package iatc_pkg;
  typedef enum logic [1:0] {CAP_CONT = 2'b00, CAP_COUNTED = 2'b01, CAP_ONESHOT = 2'b10} iatc_cap_type;
  typedef enum logic {EXP_FIXED = 1'b0, EXP_PULSE = 1'b1} iatc_exp_type;
  typedef enum logic [1:0] {AE_OFF = 2'b00, AE_ONCE = 2'b01, AE_CONT = 2'b10} iatc_ae_type;
  typedef enum logic [1:0] {KIND_ACQ = 2'b00, KIND_FRAME = 2'b01, KIND_BURST = 2'b10} iatc_kind_type;
  typedef enum logic [2:0] {ORG_LINE0 = 3'b000, ORG_LINE1 = 3'b001, ORG_USER = 3'b010,
                            ORG_CNT = 3'b011, ORG_LOGIC = 3'b100, ORG_SOFT = 3'b101} iatc_org_type;
  typedef enum logic [2:0] {SNS_LOW = 3'b000, SNS_HIGH = 3'b001, SNS_FALL = 3'b010,
                            SNS_RISE = 3'b011, SNS_ANY = 3'b100} iatc_sense_type;
  typedef enum logic [2:0] {ST_IDLE = 3'b000, ST_ARMED = 3'b001, ST_LAG = 3'b010,
                            ST_WAIT = 3'b011, ST_EXPOSE = 3'b100} iatc_state_type;
  typedef struct packed {
    logic           overlap;
    iatc_sense_type sense;
    iatc_org_type   origin;
    iatc_kind_type  kind;
    logic           trig_en;
    iatc_ae_type    ae;
    iatc_exp_type   exp_mode;
    logic           manual;
    iatc_cap_type   mode;
  } iatc_ctrl_type;
  typedef struct packed {
    logic acquiring;
    logic exposing;
    logic readout;
    logic frame_start;
  } iatc_stat_type;
endpackage : iatc_pkg
`default_nettype wire

// ---- rtl/iatc_top.sv ----
// iatc_top: acquisition and trigger sequencer with Avalon-MM register slave
// assumes trigger lines are asynchronous pins; other trigger sources and
// the auto-exposure value come from logic on mclk_i
//
// Overview of operation
// - three capture modes; continuous after reset
// - counted mode captures multi_capture_count images then stops itself
// - one-shot mode captures one image then ends acquisition
// - begin and end commands start or halt capture in selected mode
// - manual rate follows requested rate; automatic otherwise; automatic after reset
// - achieved rate reported; drops when exposure outlasts frame period
// - fixed duration exposure by default; pulse width lets trigger set length
// - fixed exposure with auto off lasts exposure_duration microseconds
// - auto once adapts then turns itself off; continuous adapts always, reset value
// - triggering disabled after reset until trigger_enable set
// - acquisition-start trigger starts capture in current mode
// - frame-start needs one trigger per image; counted/one-shot need restart
// - burst trigger yields burst, counted or one image; no restart needed
// - trigger origin: line, user output, counter, logic block or software
// - sense: low level, high level, falling, rising or either edge
// - overlap off ignores triggers in readout; overlap accept starts image
// - trigger_lag microseconds between qualified trigger and exposure start
// - each software trigger command is one trigger event
//
// Chosen here: the placing of the registers and the Avalon-MM register port.
`include "iatc_regs.svh"
`default_nettype none
module iatc_top #(
  parameter int unsigned CLK_HZ  = `IATC_CLK_HZ,
  parameter int unsigned WIN_CYC = `IATC_WIN_S * `IATC_CLK_HZ
) (
  input  wire logic               mclk_i,
  input  wire logic               reset_i,
  input  wire logic               ce_i,
  input  wire logic [5:0]         avs_address_i,
  input  wire logic               avs_read_i,
  input  wire logic               avs_write_i,
  input  wire logic [31:0]        avs_writedata_i,
  output logic      [31:0]        avs_readdata_o,
  output logic                    avs_waitrequest_o,
  input  wire logic [1:0]         trig_line_i,
  input  wire logic               user_out_i,
  input  wire logic               counter_i,
  input  wire logic               logic_blk_i,
  input  wire logic [19:0]        ae_duration_i,
  output iatc_pkg::iatc_stat_type status_o
);
  import iatc_pkg::*;

  localparam logic [7:0]  US_CYC = 8'(CLK_HZ / `IATC_US_PER_S);
  localparam logic [15:0] RO_CYC = 16'(`IATC_RO_US * (CLK_HZ / `IATC_US_PER_S));
  localparam logic [31:0] HZ     = 32'(CLK_HZ);
  localparam logic [31:0] WIN    = 32'(WIN_CYC);

  // true when the selected sense condition holds
  function automatic logic sense_hit(input iatc_sense_type s, input logic cur, input logic prv);
    case (s)
      SNS_LOW:  sense_hit = ~cur;
      SNS_HIGH: sense_hit = cur;
      SNS_FALL: sense_hit = prv & ~cur;
      SNS_RISE: sense_hit = ~prv & cur;
      SNS_ANY:  sense_hit = prv ^ cur;
      default:  sense_hit = 1'b0;
    endcase
  endfunction : sense_hit

  // ==========================================
  // state declarations
  iatc_ctrl_type  ctrl_reg, ctrl_next;
  logic [15:0]    mcount_reg, mcount_next, bcount_reg, bcount_next;
  logic [19:0]    expdur_reg, expdur_next, rate_reg, rate_next, lag_reg, lag_next;
  logic           ack_reg, ack_next;
  logic [31:0]    rdata_reg, rdata_next;
  logic [1:0]     sync1_reg, sync2_reg;
  logic           prev_reg, prev_next;
  iatc_state_type state_reg, state_next;
  logic           acq_reg, acq_next, go_reg, go_next;
  logic [15:0]    left_reg, left_next, pend_reg, pend_next, ro_reg, ro_next;
  logic [7:0]     sub_reg, sub_next;
  logic [19:0]    ucnt_reg, ucnt_next;
  logic [31:0]    acc_reg, acc_next, win_reg, win_next;
  logic           tick_reg, tick_next;
  logic [19:0]    fcnt_reg, fcnt_next, achv_reg, achv_next;
  iatc_stat_type  stat_reg, stat_next;

  logic        wr_en, cmd_wr, begin_cmd, end_cmd, soft_cmd;
  logic        src_lvl, trig_hit, trig_end, trig_acc, free_run, pace_ok;
  logic        exp_end, fstart, fdone, stop_now, ae_once_done;
  logic [19:0] exp_us;
  logic [15:0] burst_load;
  logic [32:0] acc_sum;

  // ==========================================
  // avalon slave: one wait state, answer held while ce_i is low
  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~(ack_reg & ce_i);
  assign avs_readdata_o    = rdata_reg;
  assign status_o          = stat_reg;
  assign wr_en     = ack_reg & avs_write_i;
  assign cmd_wr    = wr_en & (avs_address_i == `IATC_OFS_CMD);
  assign begin_cmd = cmd_wr & avs_writedata_i[`IATC_CMD_BEGIN];
  assign end_cmd   = cmd_wr & avs_writedata_i[`IATC_CMD_END];
  assign soft_cmd  = cmd_wr & avs_writedata_i[`IATC_CMD_SOFT];

  // register file next values; hardware clear of auto once beats a write
  always_comb begin
    ack_next    = (avs_read_i | avs_write_i) & ~ack_reg;
    rdata_next  = rdata_reg;
    ctrl_next   = ctrl_reg;
    mcount_next = mcount_reg;
    bcount_next = bcount_reg;
    expdur_next = expdur_reg;
    rate_next   = rate_reg;
    lag_next    = lag_reg;
    if (wr_en) begin
      case (avs_address_i)
        `IATC_OFS_CTRL:   ctrl_next   = iatc_ctrl_type'(avs_writedata_i[`IATC_CTRL_W-1:0]);
        `IATC_OFS_MCOUNT: mcount_next = avs_writedata_i[15:0];
        `IATC_OFS_BCOUNT: bcount_next = avs_writedata_i[15:0];
        `IATC_OFS_EXPDUR: expdur_next = avs_writedata_i[19:0];
        `IATC_OFS_RATE:   rate_next   = avs_writedata_i[19:0];
        `IATC_OFS_LAG:    lag_next    = avs_writedata_i[19:0];
        default: ;
      endcase
    end
    if (ae_once_done) begin
      ctrl_next.ae = AE_OFF;
      expdur_next  = ae_duration_i;
    end
    if (ack_next & avs_read_i) begin
      case (avs_address_i)
        `IATC_OFS_CTRL:   rdata_next = {16'h0000, ctrl_reg};
        `IATC_OFS_MCOUNT: rdata_next = {16'h0000, mcount_reg};
        `IATC_OFS_BCOUNT: rdata_next = {16'h0000, bcount_reg};
        `IATC_OFS_EXPDUR: rdata_next = {12'h000, expdur_reg};
        `IATC_OFS_RATE:   rdata_next = {12'h000, rate_reg};
        `IATC_OFS_LAG:    rdata_next = {12'h000, lag_reg};
        `IATC_OFS_STAT:   rdata_next = {25'h0000000, stat_reg, state_reg};
        `IATC_OFS_ACHV:   rdata_next = {12'h000, achv_reg};
        `IATC_OFS_LEFT:   rdata_next = {16'h0000, left_reg};
        default:          rdata_next = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      ack_reg    <= 1'b0;
      rdata_reg  <= 32'h00000000;
      ctrl_reg   <= iatc_ctrl_type'(`IATC_CTRL_RST);
      mcount_reg <= `IATC_COUNT_RST;
      bcount_reg <= `IATC_COUNT_RST;
      expdur_reg <= `IATC_EXPDUR_RST;
      rate_reg   <= `IATC_RATE_RST;
      lag_reg    <= `IATC_LAG_RST;
    end else if (ce_i) begin
      ack_reg    <= ack_next;
      rdata_reg  <= rdata_next;
      ctrl_reg   <= ctrl_next;
      mcount_reg <= mcount_next;
      bcount_reg <= bcount_next;
      expdur_reg <= expdur_next;
      rate_reg   <= rate_next;
      lag_reg    <= lag_next;
    end
  end

  // ==========================================
  // trigger source selection and detection
  always_comb begin
    case (ctrl_reg.origin)
      ORG_LINE0: src_lvl = sync2_reg[0];
      ORG_LINE1: src_lvl = sync2_reg[1];
      ORG_USER:  src_lvl = user_out_i;
      ORG_CNT:   src_lvl = counter_i;
      ORG_LOGIC: src_lvl = logic_blk_i;
      default:   src_lvl = 1'b0;
    endcase
    prev_next = src_lvl;
    // software commands are single events whatever the sense setting
    if (ctrl_reg.origin == ORG_SOFT) begin
      trig_hit = soft_cmd;
      trig_end = soft_cmd;
    end else begin
      trig_hit = sense_hit(ctrl_reg.sense, src_lvl, prev_reg);
      trig_end = (ctrl_reg.sense == SNS_LOW || ctrl_reg.sense == SNS_HIGH) ? ~trig_hit : trig_hit;
    end
  end

  // two-stage synchroniser on the pins, then the edge history
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      sync1_reg <= 2'b00;
      sync2_reg <= 2'b00;
      prev_reg  <= 1'b0;
    end else if (ce_i) begin
      sync1_reg <= trig_line_i;
      sync2_reg <= sync1_reg;
      prev_reg  <= prev_next;
    end
  end

  // ==========================================
  // qualification and sequencing
  assign trig_acc = ctrl_reg.trig_en & (state_reg == ST_ARMED) & trig_hit
                  & ((ro_reg == 16'h0000) | ctrl_reg.overlap);
  assign free_run = ~ctrl_reg.trig_en | ((ctrl_reg.kind == KIND_ACQ) & go_reg);
  assign pace_ok  = ~ctrl_reg.manual | tick_reg;
  // auto exposure only applies to fixed duration; the algorithm sits outside
  assign exp_us   = (ctrl_reg.ae == AE_OFF) ? expdur_reg : ae_duration_i;
  assign exp_end  = (ctrl_reg.exp_mode == EXP_PULSE) ? trig_end : (ucnt_reg >= exp_us);
  assign stop_now = (ctrl_reg.mode == CAP_COUNTED || ctrl_reg.mode == CAP_ONESHOT)
                  & ~(ctrl_reg.trig_en & (ctrl_reg.kind == KIND_BURST)) & (left_reg <= 16'h0001);
  assign ae_once_done = fdone & (ctrl_reg.ae == AE_ONCE) & (ctrl_reg.exp_mode == EXP_FIXED);

  always_comb begin
    case (ctrl_reg.mode)
      CAP_COUNTED: burst_load = mcount_reg;
      CAP_ONESHOT: burst_load = 16'h0001;
      default:     burst_load = bcount_reg;
    endcase
  end

  always_comb begin
    state_next = state_reg;
    acq_next   = acq_reg;
    go_next    = go_reg;
    left_next  = left_reg;
    pend_next  = pend_reg;
    sub_next   = (sub_reg == US_CYC - 8'h01) ? 8'h00 : sub_reg + 8'h01;
    ucnt_next  = ucnt_reg + 20'(sub_reg == US_CYC - 8'h01);
    ro_next    = (ro_reg != 16'h0000) ? ro_reg - 16'h0001 : ro_reg;
    fstart     = 1'b0;
    fdone      = 1'b0;
    case (state_reg)
      ST_IDLE: ;
      ST_ARMED: begin
        if (free_run) begin
          state_next = ST_WAIT;
        end else if (trig_acc) begin
          state_next = ST_LAG;
          sub_next   = 8'h00;
          ucnt_next  = 20'h00000;
          case (ctrl_reg.kind)
            KIND_FRAME: pend_next = 16'h0001;
            KIND_BURST: pend_next = burst_load;
            default:    pend_next = 16'h0000;
          endcase
        end
      end
      ST_LAG: begin
        if (ucnt_reg >= lag_reg) begin
          state_next = ST_WAIT;
          if (ctrl_reg.kind == KIND_ACQ) begin
            go_next = 1'b1;
          end
        end
      end
      ST_WAIT: begin
        if (pace_ok && (ro_reg == 16'h0000 || ctrl_reg.overlap)) begin
          state_next = ST_EXPOSE;
          fstart     = 1'b1;
          sub_next   = 8'h00;
          ucnt_next  = 20'h00000;
        end
      end
      ST_EXPOSE: begin
        if (exp_end) begin
          fdone     = 1'b1;
          ro_next   = RO_CYC;
          pend_next = (pend_reg != 16'h0000) ? pend_reg - 16'h0001 : 16'h0000;
          if (ctrl_reg.mode != CAP_CONT) begin
            left_next = (left_reg != 16'h0000) ? left_reg - 16'h0001 : 16'h0000;
          end
          if (stop_now) begin
            acq_next   = 1'b0;
            state_next = ST_IDLE;
          end else if (pend_reg > 16'h0001 || free_run) begin
            state_next = ST_WAIT;
          end else begin
            state_next = ST_ARMED;
          end
        end
      end
      default: state_next = ST_IDLE;
    endcase
    if (begin_cmd) begin
      acq_next   = 1'b1;
      go_next    = 1'b0;
      pend_next  = 16'h0000;
      left_next  = (ctrl_reg.mode == CAP_ONESHOT) ? 16'h0001 : mcount_reg;
      state_next = ST_ARMED;
    end
    if (end_cmd) begin
      acq_next   = 1'b0;
      pend_next  = 16'h0000;
      state_next = ST_IDLE;
    end
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_reg <= ST_IDLE;
      acq_reg   <= 1'b0;
      go_reg    <= 1'b0;
      left_reg  <= 16'h0000;
      pend_reg  <= 16'h0000;
      ro_reg    <= 16'h0000;
      sub_reg   <= 8'h00;
      ucnt_reg  <= 20'h00000;
    end else if (ce_i) begin
      state_reg <= state_next;
      acq_reg   <= acq_next;
      go_reg    <= go_next;
      left_reg  <= left_next;
      pend_reg  <= pend_next;
      ro_reg    <= ro_next;
      sub_reg   <= sub_next;
      ucnt_reg  <= ucnt_next;
    end
  end

  // ==========================================
  // frame pacing and achieved rate
  // phase accumulator avoids a divider; missed ticks merge so a long
  // exposure lowers the achieved rate instead of queueing frames
  always_comb begin
    acc_sum   = {1'b0, acc_reg} + {13'h0000, rate_reg};
    acc_next  = acc_reg;
    tick_next = tick_reg & ~fstart;
    if (!ctrl_reg.manual) begin
      acc_next  = 32'h00000000;
      tick_next = 1'b0;
    end else if (acc_sum >= {1'b0, HZ}) begin
      acc_next  = 32'(acc_sum - {1'b0, HZ});
      tick_next = 1'b1;
    end else begin
      acc_next  = acc_sum[31:0];
    end
    win_next  = win_reg + 32'h00000001;
    fcnt_next = fcnt_reg + 20'(fstart);
    achv_next = achv_reg;
    if (win_reg >= WIN - 32'h00000001) begin
      win_next  = 32'h00000000;
      achv_next = fcnt_next;
      fcnt_next = 20'h00000;
    end
    stat_next = '{acquiring: acq_next, exposing: (state_next == ST_EXPOSE),
                  readout: (ro_next != 16'h0000), frame_start: fstart};
  end

  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      acc_reg  <= 32'h00000000;
      tick_reg <= 1'b0;
      win_reg  <= 32'h00000000;
      fcnt_reg <= 20'h00000;
      achv_reg <= 20'h00000;
      stat_reg <= '0;
    end else if (ce_i) begin
      acc_reg  <= acc_next;
      tick_reg <= tick_next;
      win_reg  <= win_next;
      fcnt_reg <= fcnt_next;
      achv_reg <= achv_next;
      stat_reg <= stat_next;
    end
  end

  // ==========================================
  // assertions
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (reset_i);

  property p_counted_stop;
    ce_i && !cmd_wr && state_reg == ST_EXPOSE && exp_end && stop_now |=> !acq_reg && state_reg == ST_IDLE;
  endproperty
  a_counted_stop: assert property (p_counted_stop) else $error("capture did not stop at count");

  property p_oneshot_load;
    ce_i && begin_cmd && !end_cmd && ctrl_reg.mode == CAP_ONESHOT |=> left_reg == 16'h0001 && acq_reg;
  endproperty
  a_oneshot_load: assert property (p_oneshot_load) else $error("one-shot did not load one image");

  property p_end_halts;
    ce_i && end_cmd |=> state_reg == ST_IDLE && !acq_reg && !stat_reg.acquiring;
  endproperty
  a_end_halts: assert property (p_end_halts) else $error("end command did not halt");

  property p_auto_rate;
    ce_i && !ctrl_reg.manual && state_reg == ST_WAIT && ro_reg == 16'h0000 && !cmd_wr |=> state_reg == ST_EXPOSE;
  endproperty
  a_auto_rate: assert property (p_auto_rate) else $error("automatic rate stalled a frame");

  property p_pulse_close;
    ce_i && !cmd_wr && state_reg == ST_EXPOSE && ctrl_reg.exp_mode == EXP_PULSE && trig_end
      |=> state_reg != ST_EXPOSE;
  endproperty
  a_pulse_close: assert property (p_pulse_close) else $error("pulse exposure stayed open");

  property p_fixed_hold;
    ce_i && !cmd_wr && state_reg == ST_EXPOSE && ctrl_reg.exp_mode == EXP_FIXED && ucnt_reg < exp_us
      |=> state_reg == ST_EXPOSE;
  endproperty
  a_fixed_hold: assert property (p_fixed_hold) else $error("fixed exposure ended early");

  property p_trig_off;
    !ctrl_reg.trig_en |-> !trig_acc;
  endproperty
  a_trig_off: assert property (p_trig_off) else $error("trigger taken while disabled");

  property p_overlap;
    ce_i && trig_hit && state_reg == ST_ARMED && ro_reg != 16'h0000 && !ctrl_reg.overlap && !free_run
      |=> state_reg != ST_LAG;
  endproperty
  a_overlap: assert property (p_overlap) else $error("trigger taken during readout");

  property p_lag_hold;
    ce_i && !cmd_wr && state_reg == ST_LAG && ucnt_reg < lag_reg |=> state_reg == ST_LAG;
  endproperty
  a_lag_hold: assert property (p_lag_hold) else $error("lag ended early");

  property p_burst_load;
    ce_i && !begin_cmd && !end_cmd && trig_acc && !free_run && ctrl_reg.kind == KIND_BURST && ctrl_reg.mode == CAP_CONT
      |=> pend_reg == $past(bcount_reg);
  endproperty
  a_burst_load: assert property (p_burst_load) else $error("burst count not loaded");

  property p_ae_once;
    ce_i && ae_once_done |=> ctrl_reg.ae == AE_OFF && expdur_reg == $past(ae_duration_i);
  endproperty
  a_ae_once: assert property (p_ae_once) else $error("auto once did not return to off");
endmodule : iatc_top
`default_nettype wire

// ---- tb/iatc_line_model.sv ----
// iatc_line_model: trigger pins and the other trigger sources of the sequencer
// assumes pins idle low through a pull-down and change just after a clock edge
`default_nettype none
module iatc_line_model (
  input  wire logic       mclk_i,
  output logic      [1:0] line_o,
  output logic            user_o,
  output logic            cnt_o,
  output logic            blk_o
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================
  // idle level of every source
  initial begin
    {line_o, user_o, cnt_o, blk_o} = 5'h00;
  end

  // one pulse on all sources; edge senses see both edges, level senses a window
  task automatic pulse(input int width);
    @(posedge mclk_i);
    {line_o, user_o, cnt_o, blk_o} <= 5'h1f;
    repeat (width) @(posedge mclk_i);
    {line_o, user_o, cnt_o, blk_o} <= 5'h00;
  endtask : pulse
endmodule : iatc_line_model
`default_nettype wire

// ---- tb/iatc_top_tb.sv ----
// iatc_top_tb: register-level tests of the acquisition sequencer
// assumes iatc_top with a short rate window and the line model on its pins
`include "iatc_regs.svh"
`default_nettype none
module iatc_top_tb;
  timeunit 1ns;
  timeprecision 1ps;

  logic                   mclk, reset, ce, rd, wr, waitreq, user, cnt, blk;
  logic [5:0]             address;
  logic [31:0]            wdata, rdata;
  logic [1:0]             lines;
  logic [19:0]            ae_dur;
  iatc_pkg::iatc_stat_type stat;
  int                     fail_count, checked, frames, run, exp_len, f0, cyc;

  // ==========================================
  // clock, design and trigger sources
  initial begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  iatc_top #(.WIN_CYC(2000)) i_dut (.mclk_i(mclk), .reset_i(reset), .ce_i(ce), .avs_address_i(address),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wdata), .avs_readdata_o(rdata),
    .avs_waitrequest_o(waitreq), .trig_line_i(lines), .user_out_i(user), .counter_i(cnt),
    .logic_blk_i(blk), .ae_duration_i(ae_dur), .status_o(stat));

  iatc_line_model i_lines (.mclk_i(mclk), .line_o(lines), .user_o(user), .cnt_o(cnt), .blk_o(blk));

  // frame pulses and exposure length, counted by this process only
  always @(posedge mclk) begin
    if (stat.frame_start === 1'b1) frames++;
    if (stat.exposing === 1'b1) run++;
    else if (run != 0) begin
      exp_len = run;
      run = 0;
    end
  end

  // ==========================================
  // tasks
  task automatic report_and_stop();
    if (fail_count == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  // hold the request until waitrequest is seen low at a rising edge
  task automatic access(input logic [5:0] a, input logic w, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    address <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do begin
      @(posedge mclk);
      n++;
    end while (waitreq !== 1'b0 && n < 100);
    wr <= 1'b0;
    rd <= 1'b0;
    if (n >= 100) begin
      fail_count++;
      report_and_stop();
    end
  endtask : access

  task automatic rd_chk(input logic [5:0] a, input logic [31:0] exp);
    access(a, 1'b0, 32'h0);
    chk($sformatf("reg %h", a), exp, rdata);
  endtask : rd_chk

  // bounded waits: for a frame total, or for acquisition to end
  task automatic wait_frames(input int target);
    cyc = 0;
    while (frames < target && cyc < 30000) begin
      @(posedge mclk);
      cyc++;
    end
    if (cyc >= 30000) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_frames

  task automatic wait_idle();
    cyc = 0;
    @(posedge mclk); // status lags the command write by one edge
    while (stat.acquiring !== 1'b0 && cyc < 30000) begin
      @(posedge mclk);
      cyc++;
    end
    if (cyc >= 30000) begin
      fail_count++;
      report_and_stop();
    end
  endtask : wait_idle

  // ==========================================
  // main sequence
  initial begin
    {reset, ce, rd, wr, address, wdata, ae_dur} = {1'b1, 1'b1, 2'b00, 6'h00, 32'h0, 20'h00002};
    repeat (12) @(posedge mclk);
    reset <= 1'b0;
    rd_chk(`IATC_OFS_CTRL, 32'h0000_0020);
    rd_chk(`IATC_OFS_MCOUNT, 32'h0000_0001);
    rd_chk(`IATC_OFS_EXPDUR, 32'h0000_03e8);
    rd_chk(6'h3c, 32'h0);
    // counted: three frames of one microsecond, then stops by itself
    access(`IATC_OFS_CTRL, 1'b1, 32'h0001);
    access(`IATC_OFS_MCOUNT, 1'b1, 32'h3);
    access(`IATC_OFS_EXPDUR, 1'b1, 32'h1);
    f0 = frames;
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    wait_idle();
    chk("counted frames", 32'(3), 32'(frames - f0));
    chk("exposure", 32'h1, 32'(exp_len >= 199 && exp_len <= 202));
    // one-shot with auto once: one frame, then auto off and result kept
    access(`IATC_OFS_CTRL, 1'b1, 32'h0012);
    f0 = frames;
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    wait_idle();
    chk("one-shot frames", 32'(1), 32'(frames - f0));
    rd_chk(`IATC_OFS_CTRL, 32'h0000_0002);
    rd_chk(`IATC_OFS_EXPDUR, 32'h0000_0002);
    rd_chk(`IATC_OFS_STAT, 32'h0000_0010);
    rd_chk(`IATC_OFS_LEFT, 32'h0000_0000);
    // continuous runs until the end command
    access(`IATC_OFS_CTRL, 1'b1, 32'h0000);
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    wait_frames(frames + 2);
    access(`IATC_OFS_CMD, 1'b1, 32'h2);
    wait_idle();
    f0 = frames;
    repeat (3000) @(posedge mclk);
    chk("after end", 32'(f0), 32'(frames));
    // frame-start, software origin: nothing without a command, one frame each
    access(`IATC_OFS_CTRL, 1'b1, 32'h0ac0);
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    f0 = frames;
    repeat (3000) @(posedge mclk);
    chk("no trigger", 32'(f0), 32'(frames));
    access(`IATC_OFS_CMD, 1'b1, 32'h4);
    repeat (3000) @(posedge mclk);
    chk("soft frames", 32'(f0 + 1), 32'(frames));
    access(`IATC_OFS_CMD, 1'b1, 32'h4);
    wait_frames(f0 + 2);
    access(`IATC_OFS_CMD, 1'b1, 32'h2);
    // burst of two per software trigger, no restart
    access(`IATC_OFS_CTRL, 1'b1, 32'h0b40);
    access(`IATC_OFS_BCOUNT, 1'b1, 32'h2);
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    f0 = frames;
    access(`IATC_OFS_CMD, 1'b1, 32'h4);
    wait_frames(f0 + 2);
    repeat (6000) @(posedge mclk);
    chk("burst frames", 32'(f0 + 2), 32'(frames));
    access(`IATC_OFS_CMD, 1'b1, 32'h2);
    // line 0 rising edge, five microseconds of lag, overlap off
    access(`IATC_OFS_CTRL, 1'b1, 32'h30c0);
    access(`IATC_OFS_LAG, 1'b1, 32'h5);
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    f0 = frames;
    i_lines.pulse(10);
    wait_frames(f0 + 1);
    chk("lag", 32'h1, 32'(cyc + 10 >= 1000 && cyc + 10 <= 1012));
    repeat (600) @(posedge mclk);
    i_lines.pulse(10);
    chk("readout", 32'h1, 32'(stat.readout));
    repeat (3000) @(posedge mclk);
    chk("readout trigger", 32'(f0 + 1), 32'(frames));
    // pulse width on a high level: exposure follows the line, no lag
    access(`IATC_OFS_LAG, 1'b1, 32'h0);
    access(`IATC_OFS_CTRL, 1'b1, 32'h10c8);
    i_lines.pulse(300);
    repeat (20) @(posedge mclk);
    chk("pulse exposure", 32'h1, 32'(exp_len >= 296 && exp_len <= 300));
    // manual rate of 20 kHz paces two frames in 25000 cycles
    access(`IATC_OFS_RATE, 1'b1, 32'h4e20);
    access(`IATC_OFS_CTRL, 1'b1, 32'h0004);
    access(`IATC_OFS_CMD, 1'b1, 32'h1);
    f0 = frames;
    repeat (25000) @(posedge mclk);
    chk("manual rate", 32'(f0 + 2), 32'(frames));
    report_and_stop();
  end
endmodule : iatc_top_tb
`default_nettype wire
